// *** design/omb_decoder.sv ***
// Address decode, bank arbitration and memories for on-chip RAM and ROM
//
// Operation
// [RULE1] Boot memory decoded at zero, 16 kB, fixed
// [RULE2] Boot memory reads answer in one cycle
// [RULE3] Boot memory writes ignored, no error
// [RULE4] SRAM: four 16k-word banks, two 1k-word banks
// [RULE5] Each bank has its own arbiter
// [RULE6] SRAM base 0x20000000, first 256 kB striped
// [RULE7] Words rotate banks 0..3, index per four
// [RULE8] Two 4 kB regions map to small banks
// [RULE9] Uncontended bank access completes in one cycle
// [RULE10] Mirror maps each 64 kB onto one bank
// [RULE11] Mirror sits 16 MB above SRAM base
// [RULE12] Cache storage is RAM when caching off
// [RULE13] USB buffer RAM decoded at 0x50100000
// [RULE14] Flash window reads become serial transfers
// [RULE15] Cache RAM errors while cache enabled
// [RULE16] Contention resolved round robin, losers stall
// [RULE17] Holes in SRAM segment return errors
`timescale 1ns/1ps
module omb_decoder
    import omb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Master side
    input omb_req_t masterReq [NUM_MASTERS],
    output omb_resp_t masterResp [NUM_MASTERS],
    // Cache control
    input wire logic cacheEnable,
    // Serial flash engine
    output logic flashReqValid,
    output logic [23:0] flashAddr,
    input wire logic flashAck,
    input wire logic [31:0] flashData
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic omb_dec_t decode(omb_req_t r, logic cen);
        omb_dec_t d;
        d = '0;
        d.tgt = TGT_NULL;
        d.err = 1'b1;
        case (r.addr[31:24])
            // Boot memory, writes complete with no effect
            SEG_ROM: begin
                if (r.addr[23:0] < ROM_BYTES) begin
                    d.err = 1'b0; // [RULE1]
                    d.tgt = r.write ? TGT_NULL : TGT_ROM; // [RULE3]
                    d.idx = {2'h0, r.addr[13:2]};
                end
            end
            // Flash window, reads only reach the engine
            SEG_FLASH: begin
                d.err = 1'b0;
                d.tgt = r.write ? TGT_NULL : TGT_FLASH; // [RULE14]
            end
            // Cache as RAM, mirrored over the segment
            SEG_CACHE: begin
                if (!cen) begin
                    d.err = 1'b0; // [RULE12] [RULE15]
                    d.tgt = TGT_CACHE;
                    d.idx = {2'h0, r.addr[13:2]};
                end
            end
            // Striped region, then the two small banks
            SEG_SRAM: begin
                if (r.addr[23:18] == 6'h00) begin
                    d.err = 1'b0; // [RULE6]
                    d.tgt = {2'h0, r.addr[3:2]}; // [RULE7]
                    d.idx = r.addr[17:4]; // [RULE7]
                end else if (r.addr[23:13] == SMALL_BLK) begin
                    d.err = 1'b0;
                    d.tgt = TGT_SMALL0 + {3'h0, r.addr[12]}; // [RULE8]
                    d.idx = {4'h0, r.addr[11:2]};
                end
            end
            // Non-striped mirror of the large banks
            SEG_MIRROR: begin
                if (r.addr[23:18] == 6'h00) begin
                    d.err = 1'b0; // [RULE11]
                    d.tgt = {2'h0, r.addr[17:16]}; // [RULE10]
                    d.idx = r.addr[15:2];
                end
            end
            // Spare USB buffer RAM
            SEG_USB: begin
                if (r.addr[23:12] == USB_BLK) begin
                    d.err = 1'b0; // [RULE13]
                    d.tgt = TGT_USB;
                    d.idx = {4'h0, r.addr[11:2]};
                end
            end
            // Everything else is unmapped
            default: begin
                d.err = 1'b1; // [RULE17]
            end
        endcase
        return d;
    endfunction

    // Bank depth by target code
    function automatic int tgtDepth(int t);
        if (t < 4) begin
            return BIG_WORDS;
        end else if (t < 6) begin
            return SMALL_WORDS;
        end else if (t == 6) begin
            return CACHE_WORDS;
        end else if (t == 7) begin
            return USB_WORDS;
        end else begin
            return ROM_WORDS;
        end
    endfunction

    // ****************************************************************
    // Shared signals
    // ****************************************************************
    omb_dec_t dec [NUM_MASTERS];        // Decoded requests
    logic [NUM_MASTERS-1:0] take;       // Request considered now
    logic [NUM_MASTERS-1:0] won;        // Granted by its arbiter
    logic [NUM_ARB-1:0][NUM_MASTERS-1:0] reqMat;   // Per target
    logic [NUM_ARB-1:0][NUM_MASTERS-1:0] gntMat;   // Per target
    logic [31:0] readWord [NUM_ARB];    // Word read by each target
    logic [1:0] flashOwner;             // Master awaiting flash

    // ****************************************************************
    // Per-master decode and response
    // ****************************************************************
    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_master
        // Stalled while answering or waiting on flash
        assign take[m] = masterReq[m].valid && !masterResp[m].valid
            && !(flashReqValid && (flashOwner == 2'(m)));
        assign dec[m] = decode(masterReq[m], cacheEnable);

        // Requests to each arbiter
        for (genvar t = 0; t < NUM_ARB; t++) begin : g_req
            assign reqMat[t][m] = take[m] && !dec[m].err
                && (dec[m].tgt == 4'(t))
                && ((t != int'(TGT_FLASH)) || !flashReqValid);
        end

        // Grant for this master, any target
        always_comb begin
            won[m] = 1'b0;
            for (int t = 0; t < NUM_ARB; t++) begin
                won[m] = won[m] | gntMat[t][m];
            end
        end

        // Registered answer, one pulse per access
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                masterResp[m] <= '0;
            end else if (flashReqValid && flashAck
                         && (flashOwner == 2'(m))) begin
                // Flash data handed back to its owner
                masterResp[m].valid <= 1'b1; // [RULE14]
                masterResp[m].err <= 1'b0;
                masterResp[m].rdata <= flashData;
            end else if (take[m] && dec[m].err) begin
                // Unmapped or refused
                masterResp[m].valid <= 1'b1; // [RULE17] [RULE15]
                masterResp[m].err <= 1'b1;
                masterResp[m].rdata <= 32'h00000000;
            end else if (take[m] && (dec[m].tgt == TGT_NULL)) begin
                // Ignored write, no error
                masterResp[m].valid <= 1'b1; // [RULE3]
                masterResp[m].err <= 1'b0;
                masterResp[m].rdata <= 32'h00000000;
            end else if (won[m] && (dec[m].tgt != TGT_FLASH)) begin
                // Single-cycle memory access
                masterResp[m].valid <= 1'b1; // [RULE9] [RULE2]
                masterResp[m].err <= 1'b0;
                masterResp[m].rdata <= readWord[dec[m].tgt];
            end else begin
                // Losers and idle masters wait
                masterResp[m].valid <= 1'b0; // [RULE16]
                masterResp[m].err <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Per-target arbiters and memories
    // ****************************************************************
    for (genvar t = 0; t < NUM_ARB; t++) begin : g_tgt
        logic [IDX_W-1:0] selIdx;       // Word index of granted access
        logic selWr;                    // Granted access is a write
        logic [31:0] selData;           // Granted write data
        logic [3:0] selStrb;            // Granted byte enables

        // Dedicated arbiter so banks run in parallel
        omb_rr_arbiter u_arb (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .req(reqMat[t]),
            .grant(gntMat[t]) // [RULE5] [RULE16]
        );

        // Steer the winner onto the bank
        always_comb begin
            selIdx = '0;
            selWr = 1'b0;
            selData = 32'h00000000;
            selStrb = 4'h0;
            for (int m = 0; m < NUM_MASTERS; m++) begin
                if (gntMat[t][m]) begin
                    selIdx = dec[m].idx;
                    selWr = masterReq[m].write;
                    selData = masterReq[m].wdata;
                    selStrb = masterReq[m].strb;
                end
            end
        end

        if (t < int'(TGT_ROM)) begin : g_ram
            localparam int AW = $clog2(tgtDepth(t));
            logic [31:0] mem [tgtDepth(t)]; // [RULE4]

            // Byte-lane writes from the granted master
            always_ff @(posedge core_clk) begin
                if ((gntMat[t] != '0) && selWr) begin
                    for (int b = 0; b < 4; b++) begin
                        if (selStrb[b]) begin
                            mem[selIdx[AW-1:0]][8*b+:8] <= selData[8*b+:8];
                        end
                    end
                end
            end
            assign readWord[t] = mem[selIdx[AW-1:0]];
        end else if (t == int'(TGT_ROM)) begin : g_rom
            logic [31:0] rom [ROM_WORDS]; // [RULE1]

            // Contents fixed, no write path exists
            initial begin
                for (int i = 0; i < ROM_WORDS; i++) begin
                    rom[i] = 32'h00000000;
                end
            end
            assign readWord[t] = rom[selIdx[11:0]]; // [RULE2]
        end else begin : g_none
            assign readWord[t] = flashData;
        end
    end

    // ****************************************************************
    // Flash transfer launch
    // ****************************************************************
    // Hold the request until the engine acknowledges it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flashReqValid <= 1'b0;
            flashAddr <= 24'h000000;
            flashOwner <= 2'h0;
        end else if (flashReqValid) begin
            if (flashAck) begin
                flashReqValid <= 1'b0;
            end
        end else begin
            for (int m = 0; m < NUM_MASTERS; m++) begin
                if (gntMat[TGT_FLASH][m]) begin
                    flashReqValid <= 1'b1; // [RULE14]
                    flashAddr <= masterReq[m].addr[23:0];
                    flashOwner <= 2'(m);
                end
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_chk
        rom_write_ok_a: assert property ( // [RULE3]
            take[m] && masterReq[m].write
            && (masterReq[m].addr[31:14] == 18'h00000)
            |=> masterResp[m].valid && !masterResp[m].err)
            else $error("boot memory write not quietly completed");
        rom_read_fast_a: assert property ( // [RULE2]
            take[m] && !masterReq[m].write && (dec[m].tgt == TGT_ROM)
            && (reqMat[TGT_ROM] == (4'h1 << m))
            |=> masterResp[m].valid && !masterResp[m].err)
            else $error("boot memory read not answered in one cycle");
        bank_single_cycle_a: assert property ( // [RULE9]
            won[m] && (dec[m].tgt < TGT_ROM) |=> masterResp[m].valid)
            else $error("granted bank access not answered next cycle");
        stripe_rotation_a: assert property ( // [RULE7]
            take[m] && (masterReq[m].addr[31:18] == 14'h0800)
            |-> (dec[m].tgt == {2'h0, masterReq[m].addr[3:2]})
            && (dec[m].idx == masterReq[m].addr[17:4]))
            else $error("striped word routed to wrong bank or index");
        mirror_bank_a: assert property ( // [RULE10]
            take[m] && (masterReq[m].addr[31:18] == 14'h0840)
            |-> !dec[m].err
            && (dec[m].tgt == {2'h0, masterReq[m].addr[17:16]}))
            else $error("mirror access routed to wrong bank");
        small_bank_a: assert property ( // [RULE8]
            take[m] && (masterReq[m].addr[31:13] == 19'h10020)
            |-> dec[m].tgt == (TGT_SMALL0 + {3'h0, masterReq[m].addr[12]}))
            else $error("small bank region misrouted");
        cache_error_a: assert property ( // [RULE15]
            take[m] && cacheEnable && (masterReq[m].addr[31:24] == SEG_CACHE)
            |=> masterResp[m].valid && masterResp[m].err)
            else $error("cache RAM access while enabled did not error");
        sram_hole_a: assert property ( // [RULE17]
            take[m] && (masterReq[m].addr[31:24] == SEG_SRAM)
            && (masterReq[m].addr[23:18] != 6'h00)
            && (masterReq[m].addr[23:13] != SMALL_BLK)
            |=> masterResp[m].valid && masterResp[m].err)
            else $error("SRAM hole did not return an error");
        no_starve_a: assert property ( // [RULE16]
            take[m] && !dec[m].err && (dec[m].tgt < TGT_ROM)
            |-> ##[0:8] masterResp[m].valid)
            else $error("stalled master not served within bound");
    end

    for (genvar t = 0; t < NUM_ARB; t++) begin : g_chk_arb
        one_winner_a: assert property ( // [RULE5]
            $onehot0(gntMat[t]) && ((gntMat[t] & ~reqMat[t]) == '0))
            else $error("bank granted to none-requester or to two");
    end

    flash_launch_a: assert property ( // [RULE14]
        !flashReqValid && (gntMat[TGT_FLASH] != '0)
        |=> flashReqValid ##1 (!flashReqValid || $stable(flashAddr)))
        else $error("flash read not launched after grant");

    parallel_banks_c: cover property (
        won[0] && won[1] && (dec[0].tgt != dec[1].tgt));
    contention_c: cover property (
        (reqMat[0] == 4'hf) ##1 (reqMat[0] != '0));
    flash_done_c: cover property (flashReqValid && flashAck);
    cache_ram_c: cover property (won[0] && (dec[0].tgt == TGT_CACHE));

endmodule

// *** design/omb_pkg.sv ***
// Shared constants and carrier types for the on-chip memory bank decoder
package omb_pkg;

    // ****************************************************************
    // Bus sizing
    // ****************************************************************
    localparam int NUM_MASTERS = 4;     // Masters served in parallel
    localparam int NUM_ARB = 10;        // Arbitrated targets
    localparam int IDX_W = 14;          // Widest word index in a bank

    // ****************************************************************
    // Target codes
    // ****************************************************************
    localparam logic [3:0] TGT_SMALL0 = 4'h4;  // First 1k-word bank
    localparam logic [3:0] TGT_CACHE = 4'h6;   // Cache used as RAM
    localparam logic [3:0] TGT_USB = 4'h7;     // Spare USB buffer RAM
    localparam logic [3:0] TGT_ROM = 4'h8;     // Boot memory
    localparam logic [3:0] TGT_FLASH = 4'h9;   // Flash read window
    localparam logic [3:0] TGT_NULL = 4'ha;    // Completes, no effect

    // ****************************************************************
    // Segment decode (top address byte)
    // ****************************************************************
    localparam logic [7:0] SEG_ROM = 8'h00;
    localparam logic [7:0] SEG_FLASH = 8'h10;
    localparam logic [7:0] SEG_CACHE = 8'h15;
    localparam logic [7:0] SEG_SRAM = 8'h20;
    localparam logic [7:0] SEG_MIRROR = 8'h21;
    localparam logic [7:0] SEG_USB = 8'h50;
    localparam logic [23:0] ROM_BYTES = 24'h004000;   // 16 kB
    localparam logic [10:0] SMALL_BLK = 11'h020;     // 0x40000 >> 13
    localparam logic [11:0] USB_BLK = 12'h100;       // 0x100000 >> 12

    // ****************************************************************
    // Bank depths in 32-bit words
    // ****************************************************************
    localparam int BIG_WORDS = 16384;
    localparam int SMALL_WORDS = 1024;
    localparam int CACHE_WORDS = 4096;
    localparam int USB_WORDS = 1024;
    localparam int ROM_WORDS = 4096;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic valid;            // Request present
        logic write;            // Write when set
        logic [31:0] addr;      // Byte address
        logic [31:0] wdata;     // Write data
        logic [3:0] strb;       // Byte enables
    } omb_req_t;

    typedef struct packed {
        logic valid;            // Response pulse
        logic err;              // Bus error
        logic [31:0] rdata;     // Read data
    } omb_resp_t;

    typedef struct packed {
        logic [3:0] tgt;        // Target code
        logic [IDX_W-1:0] idx;  // Word index in target
        logic err;              // Unmapped or refused
    } omb_dec_t;

endpackage

// *** design/omb_rr_arbiter.sv ***
// Round-robin arbiter granting one of the masters per cycle
`timescale 1ns/1ps
module omb_rr_arbiter
    import omb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Requests and one-hot grant
    input wire logic [NUM_MASTERS-1:0] req,
    output logic [NUM_MASTERS-1:0] grant
);

    // ****************************************************************
    // Priority pointer
    // ****************************************************************
    logic [1:0] last;           // Most recently granted master
    logic [1:0] next_last;      // Pointer after this cycle

    // Search from the master after the last winner
    always_comb begin
        logic [1:0] cand;
        cand = 2'h0;
        grant = '0;
        next_last = last;
        for (int i = 1; i <= NUM_MASTERS; i++) begin
            cand = 2'(last + 2'(i));
            if (req[cand] && (grant == '0)) begin
                grant[cand] = 1'b1;
                next_last = cand;
            end
        end
    end

    // Pointer moves only on a grant
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last <= 2'h3;
        end else begin
            last <= next_last;
        end
    end

endmodule

// *** tb/omb_flash_model.sv ***
// Behavioural serial flash engine answering the decoder's read fetches
`timescale 1ns/1ps
module omb_flash_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Pace select: low answers at once, high after five cycles
    input wire logic slow,
    // Flash engine handshake
    input wire logic flashReqValid,
    input wire logic [23:0] flashAddr,
    output logic flashAck,
    output logic [31:0] flashData
);
    // ****************************************************************
    // Fetch pacing
    // ****************************************************************
    logic [2:0] waitCnt;     // Cycles spent on the current fetch
    logic [31:0] lastData;   // Word driven on flashData in the last cycle outside a wait

    // Acknowledge once the chosen wait has run out
    assign flashAck = flashReqValid && (waitCnt == (slow ? 3'h5 : 3'h0));
    // Word is only good with ack; else an inverted stale word
    assign flashData = flashAck ? {8'hc3, flashAddr} : ~lastData;

    // Wait counter and stale word tracking
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            waitCnt <= 3'h0;
            lastData <= 32'h0;
        end else if (flashReqValid && !flashAck) begin
            waitCnt <= waitCnt + 3'h1;
        end else begin
            waitCnt <= 3'h0;
            lastData <= flashData;
        end
    end
endmodule

// *** tb/tb_onchip_memory_bank_decode.sv ***
// Self-checking bench for the on-chip memory bank decoder
`timescale 1ns/1ps
module tb_onchip_memory_bank_decode;
    import omb_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic core_clk;
    logic rst_b;
    logic cacheEnable;
    logic slow;              // Flash model pace
    omb_req_t masterReq [NUM_MASTERS];
    omb_resp_t masterResp [NUM_MASTERS];
    logic flashReqValid;
    logic [23:0] flashAddr;
    logic flashAck;
    logic [31:0] flashData;
    int nFail = 0;
    int testsRun = 0;
    logic [31:0] seed = 32'h9;   // Xorshift state
    logic [31:0] addrV [4];      // Per-master address
    logic [31:0] dataV [4];      // Per-master write data
    omb_resp_t rs [4];           // Captured answers
    int lat [4];                 // Answer cycle per master
    int mSel;                    // Master used for single access
    omb_resp_t rsp;              // Single access answer
    logic [31:0] r;
    logic [3:0] seen;
    logic [31:0] expV [4];       // Data expected back per master
    logic [13:0] wIdx;           // Bank word index under test
    localparam logic [31:0] HOLES [4] = '{32'h20042000, 32'h21040000,
        32'h2003fffc + 32'h00000004 + 32'h2000, 32'h00004000};

    omb_decoder uut (.core_clk(core_clk), .rst_b(rst_b),
        .masterReq(masterReq), .masterResp(masterResp),
        .cacheEnable(cacheEnable), .flashReqValid(flashReqValid),
        .flashAddr(flashAddr), .flashAck(flashAck),
        .flashData(flashData));
    omb_flash_model partner (.core_clk(core_clk), .rst_b(rst_b),
        .slow(slow), .flashReqValid(flashReqValid),
        .flashAddr(flashAddr), .flashAck(flashAck),
        .flashData(flashData));

    // Clock at 100 MHz
    always #5 core_clk = ~core_clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input bit ok, input string msg);
        testsRun++;
        if (!ok) begin
            nFail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // Present masked requests together, hold each until answered
    task automatic run(input logic [3:0] mask, input logic wr,
        input logic [3:0] s);
        int cyc;
        logic [3:0] pend;
        @(posedge core_clk);
        for (int m = 0; m < 4; m++) begin
            lat[m] = 0;
            if (mask[m]) begin
                masterReq[m] <= '{1'b1, wr, addrV[m], dataV[m], s};
            end
        end
        pend = mask;
        cyc = 0;
        while (pend != 4'h0 && cyc < 40) begin
            // Answer is taken at the edge that closes its cycle
            @(posedge core_clk);
            cyc++;
            for (int m = 0; m < 4; m++) begin
                if (pend[m] && masterResp[m].valid === 1'b1) begin
                    rs[m] = masterResp[m];
                    lat[m] = cyc - 1;
                    pend[m] = 1'b0;
                    masterReq[m].valid <= 1'b0;
                end
            end
        end
        if (pend != 4'h0) begin
            chk(1'b0, "request never answered");
        end
    endtask

    // One access from a randomly picked master
    task automatic acc(input logic wr, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] t;
        t = rnd();
        mSel = int'(t[1:0]);
        addrV[mSel] = a;
        dataV[mSel] = d;
        run(4'h1 << mSel, wr, s);
        rsp = rs[mSel];
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, 4'hf);
        chk(rsp.err === 1'b0 && rsp.rdata === exp, "read data");
    endtask

    task tally_and_finish();
        $display("checks %0d, mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        chk(1'b0, "watchdog expired");
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        cacheEnable = 1'b1;
        slow = 1'b0;
        for (int m = 0; m < 4; m++) begin
            masterReq[m] = '0;
        end
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        // Boot memory: top word reads in one cycle, writes ignored
        rd(32'h00003ffc, 32'h0);
        chk(lat[mSel] === 1, "boot latency");
        acc(1'b1, 32'h00000010, 32'hdeadbeef, 4'hf);
        chk(rsp.err === 1'b0, "boot write erred");
        rd(32'h00000010, 32'h0);
        // Unmapped places answer with an error
        foreach (HOLES[i]) begin
            acc(1'b0, HOLES[i], 32'h0, 4'hf);
            chk(rsp.err === 1'b1, "hole not refused");
        end
        // Write via mirror, read back striped, top index included
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            wIdx = (i == 0) ? 14'h3fff : r[15:2];
            dataV[0] = rnd();
            acc(1'b1, 32'h21000000 | {r[1:0], wIdx, 2'h0}, dataV[0], 4'hf);
            chk(rsp.err === 1'b0, "mirror write");
            r = 32'h20000000 | {wIdx, r[1:0], 2'h0};
            rd(r, dataV[0]);
            chk(lat[mSel] === 1, "bank latency");
        end
        // Small banks are separate, byte strobes honoured
        acc(1'b1, 32'h20040ffc, 32'h11223344, 4'hf);
        acc(1'b1, 32'h20041ffc, 32'h55667788, 4'hf);
        acc(1'b1, 32'h20040ffc, 32'haabbccdd, 4'h1);
        rd(32'h20040ffc, 32'h112233dd);
        rd(32'h20041ffc, 32'h55667788);
        // Cache storage refused while caching on, RAM once off
        acc(1'b0, 32'h15000000, 32'h0, 4'hf);
        chk(rsp.err === 1'b1, "cache RAM open");
        @(posedge core_clk);
        cacheEnable <= 1'b0;
        acc(1'b1, 32'h15003ffc, 32'h0badf00d, 4'hf);
        rd(32'h15003ffc, 32'h0badf00d);
        // Spare USB buffer as general RAM
        acc(1'b1, 32'h50100ffc, 32'hc0ffee11, 4'hf);
        rd(32'h50100ffc, 32'hc0ffee11);
        // Flash window reads, prompt and slow engine
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk);
            slow <= s[0];
            r = 32'(s * 4);
            rd(32'h10abcd00 + r, 32'hc3abcd00 + r);
            chk(lat[mSel] === (s == 1 ? 7 : 2), "flash timing");
        end
        // Four masters on four distinct memories in parallel
        addrV = '{32'h0, 32'h20000004, 32'h20040000, 32'h50100000};
        run(4'hf, 1'b0, 4'hf);
        for (int m = 0; m < 4; m++) begin
            chk(lat[m] === 1, "parallel stalled");
        end
        // All four on one bank: one grant per cycle in rotation
        for (int k = 0; k < 2; k++) begin
            // Prime bank 0 so the first winner is known
            acc(1'b0, 32'h20000000, 32'h0, 4'hf);
            for (int m = 0; m < 4; m++) begin
                addrV[m] = 32'h20000000 + 32'(m * 16);
                expV[m] = rnd();
                dataV[m] = expV[m];
            end
            run(4'hf, 1'b1, 4'hf);
            seen = 4'h0;
            for (int m = 0; m < 4; m++) begin
                if (lat[m] >= 1 && lat[m] <= 4) begin
                    seen[lat[m] - 1] = 1'b1;
                end
            end
            chk(seen === 4'hf, "grants not one per cycle");
            for (int j = 0; j < 4; j++) begin
                chk(lat[(mSel + j + 1) % 4] === j + 1, "grant order");
            end
            for (int m = 0; m < 4; m++) begin
                rd(32'h20000000 + 32'(m * 16), expV[m]);
            end
        end
        tally_and_finish();
    end
endmodule
